// ---- include/fcv_regs.svh ----
// Purpose: Register map, field positions and command codes of the flash
//          command validator.
// Assumes: Byte addresses on the register bus, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef FCV_REGS_SVH
`define FCV_REGS_SVH

// Register byte offsets
`define FCV_OFF_CLKDIV    6'h00
`define FCV_OFF_PROT      6'h04
`define FCV_OFF_STAT      6'h08
`define FCV_OFF_INDEX     6'h0c
`define FCV_OFF_PARAM     6'h10
`define FCV_OFF_FAULT     6'h14
`define FCV_OFF_CAPADDR   6'h18
`define FCV_OFF_CAPDATA   6'h1c
`define FCV_OFF_MARGIN    6'h20

// Status register bits
`define FCV_STAT_COMMAND_COMPLETE_FLAG     7
`define FCV_STAT_ACCESS_ERROR_FLAG   5
`define FCV_STAT_PROTECTION_VIOLATION_FLAG   4
`define FCV_STAT_VERR     1
`define FCV_STAT_UNCORR   0

// Protection register bits
`define FCV_PROT_LDIS     0
`define FCV_PROT_HDIS     1
`define FCV_PROT_POPEN    2
`define FCV_PROT_DOPEN    3

// Fault register bits and divider-loaded bit
`define FCV_FAULT_SFD     0
`define FCV_FAULT_DFD     1
`define FCV_DIV_LOADED    8

// Command codes
`define FCV_CMD_EV_ALL    8'h01
`define FCV_CMD_EV_BLK    8'h02
`define FCV_CMD_EV_PSEC   8'h03
`define FCV_CMD_ERS_ALL   8'h08
`define FCV_CMD_ERS_BLK   8'h09
`define FCV_CMD_UNSECURE  8'h0b
`define FCV_CMD_USR_MRG   8'h0d
`define FCV_CMD_FLD_MRG   8'h0e
`define FCV_CMD_EV_DSEC   8'h10
`define FCV_CMD_PRG_D     8'h11
`define FCV_CMD_ERS_DSEC  8'h12

// Parameter index values
`define FCV_IDX_000       3'h0
`define FCV_IDX_001       3'h1
`define FCV_IDX_010       3'h2
`define FCV_IDX_101       3'h5

// Block decode of global address [22:16], section byte limit and divider reset value
`define FCV_DFLASH_BLK    7'h10
`define FCV_PFLASH_BIT    6
`define FCV_SECTION_LIMIT 20'h20000
`define FCV_CLKDIV_RST    8'h00

`endif

// ---- include/fcv_pkg.sv ----
// Purpose: Types of the flash command validator.
// Assumes: Nothing beyond the register header.
// Notes:   States are one-hot.
package fcv_pkg;

  typedef enum logic [2:0] {
    FCV_IDLE  = 3'b001,
    FCV_CHECK = 3'b010,
    FCV_RUN   = 3'b100
  } fcv_state_t;

  typedef enum logic [1:0] {
    FCV_REG_NONE = 2'h0,
    FCV_REG_DF   = 2'h1,
    FCV_REG_PF   = 2'h2,
    FCV_REG_ALL  = 2'h3
  } fcv_region_t;

endpackage

// ---- src/fcv_top.sv ----
// Purpose: Command launch, validation and erase-verify control of an
//          embedded flash controller, with an Avalon-MM register slave.
// Assumes: One clock, synchronous active-high reset, external engine runs
//          the erase/program/verify algorithms and reports done.
// Notes:   Each bus access takes one wait cycle.
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "fcv_regs.svh"

module fcv_top #(
  parameter int PARAM_DEPTH = 6,
  parameter int PARAM_W     = 16
) (
  input  wire logic        CLK_IN,
  input  wire logic        SRST_IN,
  input  wire logic [5:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  output logic      [31:0] AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  input  wire logic        SPECIAL_MODE_IN,
  input  wire logic        SECURED_IN,
  input  wire logic        RD_VALID_IN,
  input  wire logic [22:0] RD_ADDR_IN,
  output logic             RD_INVALID_OUT,
  output logic             ALG_START_OUT,
  output logic      [7:0]  ALG_CMD_OUT,
  output logic      [22:0] ALG_ADDR_OUT,
  output logic      [15:0] ALG_COUNT_OUT,
  input  wire logic        ALG_DONE_IN,
  input  wire logic        ALG_VERR_IN,
  input  wire logic        ALG_UNCORR_IN,
  output logic      [15:0] MARGIN_LEVEL_OUT,
  output logic             MARGIN_FIELD_OUT
);

  if (PARAM_DEPTH < 6 || PARAM_DEPTH > 8 || PARAM_W != 16) begin : g_bad
    $error("fcv_top: PARAM_DEPTH must be 6..8 and PARAM_W 16");
  end

  fcv_pkg::fcv_state_t  state;
  fcv_pkg::fcv_state_t  next_state;
  fcv_pkg::fcv_region_t busy_region;
  fcv_pkg::fcv_region_t cmd_region;

  logic [PARAM_W-1:0] param [PARAM_DEPTH];
  logic [2:0]         parameter_index;
  logic [7:0]         clock_divider_reg;
  logic               div_loaded;
  logic [3:0]         protect_bits;
  logic               command_complete_flag;
  logic               access_error_flag;
  logic               protection_violation_flag;
  logic               verify_error_flag;
  logic               uncorrectable_verify_flag;
  logic               single_fault_detect_flag;
  logic               double_fault_detect_flag;
  logic [22:0]        capture_addr;
  logic [15:0]        capture_data;
  logic [7:0]         cmd_hold;

  // Bus decode
  wire        rd_take = AVS_READ_IN && AVS_WAITREQUEST_OUT;
  wire        wr_go   = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
  wire [31:0] be_mask = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
                         {8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
  wire [31:0] wd      = AVS_WRITEDATA_IN & be_mask;
  wire        sel_div   = AVS_ADDRESS_IN == `FCV_OFF_CLKDIV;
  wire        sel_prot  = AVS_ADDRESS_IN == `FCV_OFF_PROT;
  wire        sel_stat  = AVS_ADDRESS_IN == `FCV_OFF_STAT;
  wire        sel_index = AVS_ADDRESS_IN == `FCV_OFF_INDEX;
  wire        sel_param = AVS_ADDRESS_IN == `FCV_OFF_PARAM;
  wire        sel_fault = AVS_ADDRESS_IN == `FCV_OFF_FAULT;
  wire        sel_caddr = AVS_ADDRESS_IN == `FCV_OFF_CAPADDR;
  wire        sel_cdata = AVS_ADDRESS_IN == `FCV_OFF_CAPDATA;
  wire        sel_marg  = AVS_ADDRESS_IN == `FCV_OFF_MARGIN;
  wire        idx_in_range = 32'(parameter_index) < PARAM_DEPTH;
  // Parameters are frozen while a command runs
  wire        param_wr  = wr_go && sel_param && command_complete_flag
                          && idx_in_range;

  // Launch: writing 1 to the complete flag while idle and error-free
  wire launch = wr_go && sel_stat && wd[`FCV_STAT_COMMAND_COMPLETE_FLAG]
                && command_complete_flag && state == fcv_pkg::FCV_IDLE
                && !access_error_flag && !protection_violation_flag;

  // Command decode of the loaded parameters
  wire [7:0]  cmd   = param[0][15:8];
  wire [6:0]  blk   = param[0][6:0];
  wire [22:0] gaddr = {param[0][6:0], param[1]};
  wire        blk_df = blk == `FCV_DFLASH_BLK;
  wire        blk_pf = blk[`FCV_PFLASH_BIT];
  wire        blk_ok = blk_df || blk_pf;
  wire        is_01 = cmd == `FCV_CMD_EV_ALL;
  wire        is_02 = cmd == `FCV_CMD_EV_BLK;
  wire        is_03 = cmd == `FCV_CMD_EV_PSEC;
  wire        is_08 = cmd == `FCV_CMD_ERS_ALL;
  wire        is_09 = cmd == `FCV_CMD_ERS_BLK;
  wire        is_0b = cmd == `FCV_CMD_UNSECURE;
  wire        is_0d = cmd == `FCV_CMD_USR_MRG;
  wire        is_0e = cmd == `FCV_CMD_FLD_MRG;
  wire        is_10 = cmd == `FCV_CMD_EV_DSEC;
  wire        is_11 = cmd == `FCV_CMD_PRG_D;
  wire        is_12 = cmd == `FCV_CMD_ERS_DSEC;
  wire        code_ok = is_01 || is_02 || is_03 || is_08 || is_09 || is_0b
                        || is_0d || is_0e || is_10 || is_11 || is_12;
  wire        is_margin = is_0d || is_0e;
  wire        is_verify = is_01 || is_02 || is_03 || is_10 || is_0b;
  wire        needs_div = is_08 || is_09 || is_0b || is_11 || is_12;

  // Section end in bytes within a 128K window; count is in phrases
  wire [19:0] sec_end = 20'({3'h0, gaddr[16:0]}) + 20'({param[2], 3'h0});
  wire        sec_cross = sec_end > `FCV_SECTION_LIMIT;

  wire idx0 = parameter_index == `FCV_IDX_000;
  wire idx1 = parameter_index == `FCV_IDX_001;
  wire idx2 = parameter_index == `FCV_IDX_010;
  wire err_div = needs_div && !div_loaded;
  wire err_01  = is_01 && !idx0;
  wire err_02  = is_02 && (!idx0 || !blk_ok);
  wire err_03  = is_03 && (!idx2 || SECURED_IN || !blk_pf
                 || gaddr[2:0] != 3'h0 || sec_cross);
  wire err_sp  = (is_08 || is_0b || is_0e) && !SPECIAL_MODE_IN;
  wire err_09  = is_09 && (!idx1 || !blk_ok);
  wire err_mrg = is_margin && !idx1;
  wire err_10  = is_10 && (!idx2 || !blk_df || gaddr[0]);
  wire err_11  = is_11 && (parameter_index < `FCV_IDX_010
                 || parameter_index > `FCV_IDX_101 || !blk_df || gaddr[0]);
  wire err_12  = is_12 && (!idx1 || !blk_df);
  wire acc_err = !code_ok || err_div || err_01 || err_02 || err_03
                 || err_sp || err_09 || err_mrg || err_10 || err_11 || err_12;

  wire pf_open = protect_bits[`FCV_PROT_LDIS] && protect_bits[`FCV_PROT_HDIS]
                 && protect_bits[`FCV_PROT_POPEN];
  wire df_open = protect_bits[`FCV_PROT_DOPEN];
  wire prot_err = (is_08 && !(pf_open && df_open))
                  || (is_09 && blk_df && !df_open)
                  || (is_09 && blk_pf && !pf_open);

  always_comb begin
    if (is_01 || is_08 || is_0b) begin
      cmd_region = fcv_pkg::FCV_REG_ALL;
    end else if (is_03 || ((is_02 || is_09) && blk_pf)) begin
      cmd_region = fcv_pkg::FCV_REG_PF;
    end else begin
      cmd_region = fcv_pkg::FCV_REG_DF;
    end
  end

  // Sequencer
  wire in_check = state == fcv_pkg::FCV_CHECK;
  wire in_run   = state == fcv_pkg::FCV_RUN;
  wire chk_acc  = in_check && acc_err;
  wire chk_prot = in_check && !acc_err && prot_err;
  wire chk_mrg  = in_check && !acc_err && !prot_err && is_margin;
  wire chk_go   = in_check && !acc_err && !prot_err && !is_margin;
  wire run_end  = in_run && ALG_DONE_IN;
  wire hold_verify = cmd_hold == `FCV_CMD_EV_ALL
                     || cmd_hold == `FCV_CMD_EV_BLK
                     || cmd_hold == `FCV_CMD_EV_PSEC
                     || cmd_hold == `FCV_CMD_EV_DSEC
                     || cmd_hold == `FCV_CMD_UNSECURE;

  always_comb begin
    next_state = state;
    unique case (state)
      fcv_pkg::FCV_IDLE: begin
        if (launch) begin
          next_state = fcv_pkg::FCV_CHECK;
        end
      end
      fcv_pkg::FCV_CHECK: begin
        // Rejected or margin commands return straight to idle
        next_state = chk_go ? fcv_pkg::FCV_RUN : fcv_pkg::FCV_IDLE;
      end
      fcv_pkg::FCV_RUN: begin
        if (ALG_DONE_IN) begin
          next_state = fcv_pkg::FCV_IDLE;
        end
      end
      default: next_state = fcv_pkg::FCV_IDLE;
    endcase
  end

  // Status flags; hardware sets win over software clears
  wire clr_stat = wr_go && sel_stat;
  wire next_command_complete_flag = (command_complete_flag && !launch)
                   || chk_acc || chk_prot || chk_mrg || run_end;
  wire next_acc = chk_acc || (access_error_flag
                  && !(clr_stat && wd[`FCV_STAT_ACCESS_ERROR_FLAG]));
  wire next_pviol = chk_prot || (protection_violation_flag
                    && !(clr_stat && wd[`FCV_STAT_PROTECTION_VIOLATION_FLAG]));
  // Verify results clear at launch and never touch the protection flag
  wire next_verr = !launch && (verify_error_flag
                   || (run_end && hold_verify && ALG_VERR_IN));
  wire next_unc  = !launch && (uncorrectable_verify_flag
                   || (run_end && hold_verify && ALG_UNCORR_IN));

  // Colliding array read while an algorithm runs
  wire rd_df = RD_ADDR_IN[22:16] == `FCV_DFLASH_BLK;
  wire rd_pf = RD_ADDR_IN[22:16] >> `FCV_PFLASH_BIT != 7'h0;
  wire rd_hit = RD_VALID_IN && !command_complete_flag
                && (busy_region == fcv_pkg::FCV_REG_ALL
                    || (busy_region == fcv_pkg::FCV_REG_DF && rd_df)
                    || (busy_region == fcv_pkg::FCV_REG_PF && rd_pf));
  wire fault_cap = rd_hit && !single_fault_detect_flag
                   && !double_fault_detect_flag;
  wire clr_fault = wr_go && sel_fault;
  wire next_sfd = fault_cap || (single_fault_detect_flag
                  && !(clr_fault && wd[`FCV_FAULT_SFD]));
  wire next_dfd = fault_cap || (double_fault_detect_flag
                  && !(clr_fault && wd[`FCV_FAULT_DFD]));

  // Read mux
  wire [31:0] stat_word = 32'({command_complete_flag, 1'b0, access_error_flag,
                          protection_violation_flag, 2'h0, verify_error_flag,
                          uncorrectable_verify_flag});
  wire [31:0] rd_mux =
      sel_div   ? 32'({div_loaded, clock_divider_reg}) :
      sel_prot  ? 32'(protect_bits) :
      sel_stat  ? stat_word :
      sel_index ? 32'(parameter_index) :
      sel_param ? (idx_in_range ? 32'(param[parameter_index]) : 32'h0) :
      sel_fault ? 32'({double_fault_detect_flag, single_fault_detect_flag}) :
      sel_caddr ? 32'(capture_addr) :
      sel_cdata ? 32'(capture_data) :
      sel_marg  ? 32'({MARGIN_FIELD_OUT, MARGIN_LEVEL_OUT}) : 32'h0;

  // Parameter array, one entry per index below PARAM_DEPTH
  for (genvar i = 0; i < PARAM_DEPTH; i++) begin : g_param
    always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
        param[i] <= 16'h0;
      end else if (param_wr && 32'(parameter_index) == i) begin
        param[i] <= wd[15:0];
      end
    end
  end

  // Bus slave: one wait cycle, read data loaded with the wait release
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      AVS_WAITREQUEST_OUT <= 1'b1;
      AVS_READDATA_OUT    <= 32'h0;
    end else begin
      AVS_WAITREQUEST_OUT <= !((AVS_READ_IN || AVS_WRITE_IN)
                               && AVS_WAITREQUEST_OUT);
      if (rd_take) begin
        AVS_READDATA_OUT <= rd_mux;
      end
    end
  end

  // Software-written control registers
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      clock_divider_reg <= `FCV_CLKDIV_RST;
      div_loaded        <= 1'b0;
      protect_bits      <= 4'h0;
      parameter_index   <= 3'h0;
    end else if (wr_go) begin
      if (sel_div && command_complete_flag) begin
        clock_divider_reg <= wd[7:0];
        div_loaded        <= 1'b1;
      end
      if (sel_prot) begin
        protect_bits <= wd[3:0];
      end
      if (sel_index) begin
        parameter_index <= wd[2:0];
      end
    end
  end

  // Sequencer state and flags
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      state                     <= fcv_pkg::FCV_IDLE;
      command_complete_flag     <= 1'b1;
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
      verify_error_flag         <= 1'b0;
      uncorrectable_verify_flag <= 1'b0;
      single_fault_detect_flag  <= 1'b0;
      double_fault_detect_flag  <= 1'b0;
    end else begin
      state                     <= next_state;
      command_complete_flag     <= next_command_complete_flag;
      access_error_flag         <= next_acc;
      protection_violation_flag <= next_pviol;
      verify_error_flag         <= next_verr;
      uncorrectable_verify_flag <= next_unc;
      single_fault_detect_flag  <= next_sfd;
      double_fault_detect_flag  <= next_dfd;
    end
  end

  // Fault capture: data forced to zero on a collision
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      capture_addr   <= 23'h0;
      capture_data   <= 16'h0;
      RD_INVALID_OUT <= 1'b0;
    end else begin
      RD_INVALID_OUT <= rd_hit;
      if (fault_cap) begin
        capture_addr <= RD_ADDR_IN;
        capture_data <= 16'h0;
      end
    end
  end

  // Algorithm engine handoff
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      ALG_START_OUT <= 1'b0;
      ALG_CMD_OUT   <= 8'h0;
      ALG_ADDR_OUT  <= 23'h0;
      ALG_COUNT_OUT <= 16'h0;
      cmd_hold      <= 8'h0;
      busy_region   <= fcv_pkg::FCV_REG_NONE;
    end else begin
      ALG_START_OUT <= chk_go;
      if (chk_go) begin
        ALG_CMD_OUT   <= cmd;
        ALG_ADDR_OUT  <= gaddr;
        ALG_COUNT_OUT <= param[2];
        cmd_hold      <= cmd;
        busy_region   <= cmd_region;
      end else if (run_end) begin
        busy_region <= fcv_pkg::FCV_REG_NONE;
      end
    end
  end

  // Margin levels take effect at once; no array algorithm is needed
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      MARGIN_LEVEL_OUT <= 16'h0;
      MARGIN_FIELD_OUT <= 1'b0;
    end else if (chk_mrg) begin
      MARGIN_LEVEL_OUT <= param[1];
      MARGIN_FIELD_OUT <= is_0e;
    end
  end

endmodule // fcv_top

// ---- tb/fcv_monitor.sv ----
// Purpose: Concurrent checks on launch, start, margin and read ports.
// Assumes: A launch is answered two edges after its status write completes.
// Notes:   Bound to the top module; sees its ports only.
`timescale 1ns/1ps
`include "fcv_regs.svh"
module fcv_monitor (
  input  wire logic        CLK_IN,
  input  wire logic        SRST_IN,
  input  wire logic [5:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic        AVS_WAITREQUEST_OUT,
  input  wire logic        RD_VALID_IN,
  input  wire logic [22:0] RD_ADDR_IN,
  input  wire logic        RD_INVALID_OUT,
  input  wire logic        ALG_START_OUT,
  input  wire logic [7:0]  ALG_CMD_OUT,
  input  wire logic [22:0] ALG_ADDR_OUT,
  input  wire logic        ALG_DONE_IN,
  input  wire logic [15:0] MARGIN_LEVEL_OUT
);
  logic launch_q1;
  logic launch_q2;
  logic alg_busy;
  wire  launch = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT &&
                 AVS_ADDRESS_IN == `FCV_OFF_STAT &&
                 AVS_WRITEDATA_IN[`FCV_STAT_COMMAND_COMPLETE_FLAG];
  // Conservative idle: excludes the whole launch window, not just the run
  wire  quiet = !alg_busy && !launch && !launch_q1 && !launch_q2;
  wire  df_hit = alg_busy && !ALG_DONE_IN && RD_VALID_IN &&
                 ALG_CMD_OUT == `FCV_CMD_EV_DSEC &&
                 RD_ADDR_IN[22:16] == `FCV_DFLASH_BLK;

  always_ff @(posedge CLK_IN) begin
    launch_q1 <= !SRST_IN && launch;
    launch_q2 <= !SRST_IN && launch_q1;
    alg_busy  <= !SRST_IN && (ALG_START_OUT || (alg_busy && !ALG_DONE_IN));
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);

  start_after_launch_a: assert property (
    $rose(ALG_START_OUT) |-> launch_q2) else $error("start without launch");
  start_one_cycle_a: assert property (
    ALG_START_OUT |=> !ALG_START_OUT) else $error("start pulse too long");
  no_start_busy_a: assert property (
    ALG_START_OUT |-> !alg_busy) else $error("start while engine busy");
  cmd_held_a: assert property (
    !ALG_START_OUT |-> $stable(ALG_CMD_OUT) && $stable(ALG_ADDR_OUT))
    else $error("engine command changed between starts");
  invalid_cause_a: assert property (
    RD_INVALID_OUT |-> $past(RD_VALID_IN)) else $error("invalid without read");
  invalid_idle_a: assert property (
    RD_VALID_IN && quiet |=> !RD_INVALID_OUT) else $error("idle read flagged");
  invalid_busy_a: assert property (
    df_hit |=> RD_INVALID_OUT) else $error("colliding read not flagged");
  margin_launch_a: assert property (
    $changed(MARGIN_LEVEL_OUT) |-> launch_q2) else $error("margin moved alone");

  cover property (ALG_START_OUT);
  cover property (RD_INVALID_OUT);
  cover property ($changed(MARGIN_LEVEL_OUT));
endmodule // fcv_monitor

bind fcv_top fcv_monitor mon_u (
  .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
  .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
  .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .RD_VALID_IN(RD_VALID_IN),
  .RD_ADDR_IN(RD_ADDR_IN), .RD_INVALID_OUT(RD_INVALID_OUT),
  .ALG_START_OUT(ALG_START_OUT), .ALG_CMD_OUT(ALG_CMD_OUT),
  .ALG_ADDR_OUT(ALG_ADDR_OUT), .ALG_DONE_IN(ALG_DONE_IN),
  .MARGIN_LEVEL_OUT(MARGIN_LEVEL_OUT));

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the flash command validator.
// Assumes: Engine is emulated here: done pulse a few cycles after start.
// Notes:   Byte enables are tied on; the block masks nothing we need.
`timescale 1ns/1ps
`include "fcv_regs.svh"
module testbench;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  addr = 6'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wait_req;
  logic        special = 1'b0;
  logic        secured = 1'b0;
  logic        rd_valid = 1'b0;
  logic [22:0] rd_addr = 23'h0;
  logic        rd_invalid;
  logic        alg_start;
  logic [7:0]  alg_cmd;
  logic [22:0] alg_addr;
  logic [15:0] alg_count;
  logic        alg_done = 1'b0;
  logic        alg_verr = 1'b0;
  logic        alg_unc = 1'b0;
  logic [15:0] margin;
  logic        field;
  logic [31:0] rv;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          n_start = 0;

  always #20 clk = ~clk;
  always @(posedge clk) if (alg_start === 1'b1) n_start++;

  fcv_top dut_u (
    .CLK_IN(clk), .SRST_IN(srst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
    .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hf),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_req),
    .SPECIAL_MODE_IN(special), .SECURED_IN(secured), .RD_VALID_IN(rd_valid),
    .RD_ADDR_IN(rd_addr), .RD_INVALID_OUT(rd_invalid),
    .ALG_START_OUT(alg_start), .ALG_CMD_OUT(alg_cmd), .ALG_ADDR_OUT(alg_addr),
    .ALG_COUNT_OUT(alg_count), .ALG_DONE_IN(alg_done),
    .ALG_VERR_IN(alg_verr), .ALG_UNCORR_IN(alg_unc),
    .MARGIN_LEVEL_OUT(margin), .MARGIN_FIELD_OUT(field));

  task automatic stop_test;
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until waitrequest is sampled low; only the watchdog ends it
  task automatic bus(input logic is_wr, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= !is_wr;
    wr <= is_wr;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rv, exp);
  endtask

  task automatic launch(input logic [7:0] cmd, input logic [6:0] blk,
                        input logic [15:0] a1, input logic [15:0] cnt,
                        input logic [2:0] idx);
    bus(1'b1, `FCV_OFF_INDEX, 32'h0);
    bus(1'b1, `FCV_OFF_PARAM, {16'h0, cmd, 1'b0, blk});
    bus(1'b1, `FCV_OFF_INDEX, 32'h1);
    bus(1'b1, `FCV_OFF_PARAM, {16'h0, a1});
    bus(1'b1, `FCV_OFF_INDEX, 32'h2);
    bus(1'b1, `FCV_OFF_PARAM, {16'h0, cnt});
    bus(1'b1, `FCV_OFF_INDEX, {29'h0, idx});
    bus(1'b1, `FCV_OFF_STAT, 32'h80);
  endtask

  task automatic refuse(input logic [7:0] cmd, input logic [6:0] blk,
                        input logic [15:0] a1, input logic [15:0] cnt,
                        input logic [2:0] idx, input logic [31:0] stat);
    int s;
    s = n_start;
    launch(cmd, blk, a1, cnt, idx);
    repeat (4) @(posedge clk);
    rd_chk(`FCV_OFF_STAT, stat);
    check(n_start - s, 32'h0);
    bus(1'b1, `FCV_OFF_STAT, 32'h30);
  endtask

  // Expectation given per call: idle or other-region reads must stay valid
  task automatic collide(input logic [22:0] a, input logic exp);
    @(posedge clk);
    rd_valid <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_valid <= 1'b0;
    @(posedge clk);
    check({31'h0, rd_invalid}, {31'h0, exp});
  endtask

  task automatic run(input logic [7:0] cmd, input logic [6:0] blk,
                     input logic [15:0] a1, input logic [15:0] cnt,
                     input logic [2:0] idx, input logic ve, input logic un,
                     input logic hit);
    int s;
    s = n_start;
    launch(cmd, blk, a1, cnt, idx);
    repeat (10) if (n_start == s) @(posedge clk);
    check(n_start - s, 32'h1);
    check({24'h0, alg_cmd}, {24'h0, cmd});
    check({9'h0, alg_addr}, {9'h0, blk, a1});
    check({16'h0, alg_count}, {16'h0, cnt});
    rd_chk(`FCV_OFF_STAT, 32'h0);
    if (hit) begin
      collide({blk, a1}, 1'b1);
      collide(23'h400000, 1'b0);
      rd_chk(`FCV_OFF_FAULT, 32'h3);
      rd_chk(`FCV_OFF_CAPDATA, 32'h0);
      collide({blk, a1 + 16'h8}, 1'b1);
      rd_chk(`FCV_OFF_CAPADDR, {9'h0, blk, a1});
      bus(1'b1, `FCV_OFF_FAULT, 32'h3);
    end
    @(posedge clk);
    alg_done <= 1'b1;
    alg_verr <= ve;
    alg_unc <= un;
    @(posedge clk);
    alg_done <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(`FCV_OFF_STAT, {24'h0, 6'h20, ve, un});
  endtask

  task automatic t_reset_div;
    collide(23'h100000, 1'b0);
    rd_chk(`FCV_OFF_STAT, 32'h80);
    rd_chk(6'h3c, 32'h0);
    refuse(`FCV_CMD_ERS_DSEC, 7'h10, 16'h0, 16'h0, 3'h1, 32'ha0);
    bus(1'b1, `FCV_OFF_CLKDIV, 32'h1);
    rd_chk(`FCV_OFF_CLKDIV, 32'h101);
  endtask

  task automatic t_bad_codes;
    refuse(8'h00, 7'h10, 16'h0, 16'h0, 3'h0, 32'ha0);
    refuse(8'h0f, 7'h10, 16'h0, 16'h0, 3'h0, 32'ha0);
    refuse(8'hff, 7'h10, 16'h0, 16'h0, 3'h0, 32'ha0);
  endtask

  // Data-flash set; verify bits must clear at the next launch
  task automatic t_dflash;
    bus(1'b1, `FCV_OFF_PROT, 32'h8);
    run(8'h01, 7'h00, 16'h0, 16'h0, 3'h0, 1'b1, 1'b1, 1'b0);
    run(8'h02, 7'h10, 16'h0, 16'h0, 3'h0, 1'b1, 1'b0, 1'b0);
    run(8'h10, 7'h10, 16'h40, 16'h4, 3'h2, 1'b0, 1'b1, 1'b1);
    run(8'h11, 7'h10, 16'h8, 16'h0, 3'h5, 1'b0, 1'b0, 1'b0);
    run(8'h12, 7'h10, 16'h100, 16'h0, 3'h1, 1'b0, 1'b0, 1'b0);
    run(8'h09, 7'h10, 16'h0, 16'h0, 3'h1, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_protect_mode;
    bus(1'b1, `FCV_OFF_PROT, 32'h0);
    refuse(8'h09, 7'h10, 16'h0, 16'h0, 3'h1, 32'h90);
    refuse(8'h0b, 7'h00, 16'h0, 16'h0, 3'h0, 32'ha0);
    refuse(8'h0e, 7'h10, 16'h5, 16'h0, 3'h1, 32'ha0);
    special <= 1'b1;
    bus(1'b1, `FCV_OFF_PROT, 32'h7);
    refuse(8'h08, 7'h00, 16'h0, 16'h0, 3'h0, 32'h90);
    bus(1'b1, `FCV_OFF_PROT, 32'hf);
    run(8'h08, 7'h00, 16'h0, 16'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    run(8'h0b, 7'h00, 16'h0, 16'h0, 3'h0, 1'b1, 1'b0, 1'b0);
  endtask

  task automatic t_margin;
    launch(8'h0e, 7'h10, 16'h456, 16'h0, 3'h1);
    repeat (4) @(posedge clk);
    check({15'h0, field, margin}, 32'h10456);
    special <= 1'b0;
    launch(8'h0d, 7'h10, 16'h123, 16'h0, 3'h1);
    repeat (4) @(posedge clk);
    check({15'h0, field, margin}, 32'h00123);
    rd_chk(`FCV_OFF_STAT, 32'h80);
  endtask

  // Index, block, alignment and 128K-boundary faults, plus the exact edge
  task automatic t_index_addr;
    refuse(8'h01, 7'h00, 16'h0, 16'h0, 3'h1, 32'ha0);
    refuse(8'h02, 7'h05, 16'h0, 16'h0, 3'h0, 32'ha0);
    refuse(8'h02, 7'h10, 16'h0, 16'h0, 3'h1, 32'ha0);
    refuse(8'h03, 7'h40, 16'h0, 16'h1, 3'h1, 32'ha0);
    refuse(8'h03, 7'h40, 16'h4, 16'h1, 3'h2, 32'ha0);
    refuse(8'h03, 7'h05, 16'h0, 16'h1, 3'h2, 32'ha0);
    refuse(8'h03, 7'h41, 16'hfff8, 16'h2, 3'h2, 32'ha0);
    run(8'h03, 7'h41, 16'hfff8, 16'h1, 3'h2, 1'b0, 1'b0, 1'b0);
    secured <= 1'b1;
    refuse(8'h03, 7'h40, 16'h0, 16'h1, 3'h2, 32'ha0);
    secured <= 1'b0;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_reset_div;
    t_bad_codes;
    t_dflash;
    t_protect_mode;
    t_margin;
    t_index_addr;
    stop_test;
  end

  // Whole run needs about a thousand cycles; this is ample headroom
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test;
  end
endmodule // testbench
